// *** rtl/interrupt_priority_delivery.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - External interrupt pins 0..3 are captured as clock ratio and delay configuration at reset.
// - Except halt and serial line requests, a source is enabled only when current level is below its target level.
// - Fifteen software requests, request n has target level n.
// - Pending async trap for current or more privileged mode requests level 2.
// - Machine check pin and correctable error pending share target level 31.
// - External pins 0..3 map to levels 20..23, each individually maskable.
// - Delivery happens only outside privileged library code; others wait.
// - Pipeline is fully drained before vectoring, acting as a trap barrier.
// - Taking an interrupt saves restart address and enters privileged library mode.
// - Cause is readable in identification and summary registers.
// - Pin requests are level sensitive; perf counter and correctable error events stay pending until cleared.
// - Interrupt registers are reached only by privileged move instructions, by index.
module interrupt_priority_delivery
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  ext_irq,
   input  wire logic        powerfail_irq,
   input  wire logic        machine_check_irq,
   input  wire logic        halt_irq,
   input  wire logic        perf_counter_event,
   input  wire logic        correctable_error_event,
   input  wire logic        serial_line_irq,
   input  wire logic [1:0]  current_mode,
   input  wire logic        pipe_drained,
   input  wire logic [63:0] restart_pc,
   input  wire logic        library_return,
   input  wire logic        move_to_internal_register,
   input  wire logic        move_from_internal_register,
   input  wire logic [9:0]  register_index,
   input  wire logic [63:0] write_data,
   output logic [63:0]      read_data,
   output logic             drain_request,
   output logic             interrupt_taken,
   output logic             privileged_library_mode,
   output logic [3:0]       clock_config,
   output logic             clock_config_valid
);
   import irq_delivery_pkg::*;
   default clocking check_clk @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ******************************************************
   // Helpers
   // ******************************************************
   function automatic logic [4:0] highest_level(input logic [31:0] vec);
      logic [4:0] lvl = 5'h00;
      for (int i = 1; i < 32; i++)
         if (vec[i])
            lvl = 5'(i);
      return lvl;
   endfunction : highest_level

   function automatic logic [31:0] above_level(input logic [4:0] priority_level);
      logic [31:0] m = 32'h0;
      for (int i = 0; i < 32; i++)
         m[i] = (5'(i) > priority_level);
      return m;
   endfunction : above_level

   // ******************************************************
   // Pin synchronisers and configuration capture
   // ******************************************************
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end
      else
      begin
         pin_meta <= {halt_irq, machine_check_irq, powerfail_irq, 1'b0, ext_irq};
         pin_sync <= pin_meta;
      end
   end

   wire logic [3:0] ext_lvl  = pin_sync[3:0];
   wire logic       pf_lvl   = pin_sync[5];
   wire logic       mc_lvl   = pin_sync[6];
   wire logic       halt_lvl = pin_sync[7];
   logic [1:0]      cfg_count;

   // Capture waits for the synchroniser to fill, so no pin is read raw
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_count          <= 2'h0;
         clock_config       <= 4'h0;
         clock_config_valid <= 1'b0;
      end
      else if (!clock_config_valid)
      begin
         cfg_count <= cfg_count + 2'h1;
         if (cfg_count == 2'(CFG_SYNC_CYCLES))
         begin
            clock_config       <= ext_lvl;
            clock_config_valid <= 1'b1;
         end
      end
   end
   property p_config_capture;
      $rose(clock_config_valid) |-> clock_config == $past(ext_lvl);
   endproperty
   a_config_capture: assert property (p_config_capture)
      else $error("clock configuration not taken from pins");

   // ******************************************************
   // Software visible state
   // ******************************************************
   logic [SWI_COUNT:1]   swi_req;
   logic [3:0]           ast_req;
   logic [3:0]           ast_en;
   logic [63:0]          restart_addr;
   logic [4:0]           priority_level;
   logic [3:0]           ext_mask;
   logic                 corr_pending;
   logic                 perf_pending;
   deliver_state_t       state;

   wire logic wr_ok = move_to_internal_register && privileged_library_mode;
   wire logic rd_ok = move_from_internal_register && privileged_library_mode;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         swi_req  <= '0;
         ast_req  <= 4'h0;
         ast_en   <= 4'h0;
         priority_level      <= RST_PRIORITY_LEVEL;
         ext_mask <= RST_EXT_MASK;
      end
      else if (wr_ok)
      begin
         case (register_index)
            IDX_SOFTWARE_INTERRUPT_REQUEST: swi_req  <= write_data[SWI_COUNT:SWI_LSB];
            IDX_ASYNC_TRAP_REQUEST:         ast_req  <= write_data[AST_MODES-1:0];
            IDX_ASYNC_TRAP_ENABLE:          ast_en   <= write_data[AST_MODES-1:0];
            IDX_CURRENT_PRIORITY_LEVEL:     priority_level      <= write_data[4:0];
            IDX_FETCH_UNIT_CONTROL_STATUS:  ext_mask <= write_data[FETCH_UNIT_CONTROL_STATUS_MASK_LSB+:EXT_PINS];
            default:                        ;
         endcase
      end
   end

   // Hardware events win over a clear in the same cycle
   wire logic clr_wr = wr_ok && (register_index == IDX_HARDWARE_INTERRUPT_CLEAR);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         corr_pending <= 1'b0;
         perf_pending <= 1'b0;
      end
      else
      begin
         if (correctable_error_event)
            corr_pending <= 1'b1;
         else if (clr_wr && write_data[CLR_CORR_BIT])
            corr_pending <= 1'b0;
         if (perf_counter_event)
            perf_pending <= 1'b1;
         else if (clr_wr && write_data[CLR_PERF_BIT])
            perf_pending <= 1'b0;
      end
   end

   // ******************************************************
   // Priority evaluation
   // ******************************************************
   logic        ast_pending;
   logic [31:0] level_req;
   logic [31:0] level_enabled;
   logic        unmaskable_req;
   logic        deliverable;
   logic [4:0]  ident;

   always_comb
   begin
      ast_pending = 1'b0;
      level_req   = 32'h0;
      // Mode 0 is most privileged, so modes up to the current one count
      for (int m = 0; m < AST_MODES; m++)
         if ((2'(m) <= current_mode) && ast_req[m] && ast_en[m])
            ast_pending = 1'b1;
      level_req[SWI_COUNT:SWI_LSB] = swi_req;
      if (ast_pending)
         level_req[LVL_AST] = 1'b1;
      for (int p = 0; p < EXT_PINS; p++)
         if (ext_lvl[p] && !ext_mask[p])
            level_req[LVL_EXT_BASE + 5'(p)] = 1'b1;
      if (perf_pending)
         level_req[LVL_PERF] = 1'b1;
      if (pf_lvl)
         level_req[LVL_POWERFAIL] = 1'b1;
      if (mc_lvl || corr_pending)
         level_req[LVL_MCHECK] = 1'b1;
   end

   assign level_enabled  = level_req & above_level(priority_level);
   assign unmaskable_req = halt_lvl || serial_line_irq;
   assign deliverable    = (|level_enabled) || unmaskable_req;
   assign ident          = highest_level(level_enabled);
   property p_enable_strict;
      (ident != 5'h00) |-> (ident > priority_level) && level_req[ident];
   endproperty
   a_enable_strict: assert property (p_enable_strict)
      else $error("reported level not above current level");
   property p_highest_reported;
      level_enabled[LVL_MCHECK] |-> (ident == LVL_MCHECK);
   endproperty
   a_highest_reported: assert property (p_highest_reported)
      else $error("highest pending level not reported");
   property p_ext_pin_level;
      (ext_lvl[1] && !ext_mask[1] && priority_level < 5'h15) |-> level_enabled[21];
   endproperty
   a_ext_pin_level: assert property (p_ext_pin_level)
      else $error("external pin 1 not at level 21");
   property p_swi_level;
      (swi_req == 15'h0010 && priority_level < 5'h05) |-> (ident >= 5'h05);
   endproperty
   a_swi_level: assert property (p_swi_level)
      else $error("software request 5 not at level 5");
   property p_corr_sticky;
      correctable_error_event |=> corr_pending ##0 level_req[LVL_MCHECK];
   endproperty
   a_corr_sticky: assert property (p_corr_sticky)
      else $error("correctable error not pending at level 31");

   // ******************************************************
   // Delivery sequence
   // ******************************************************
   // A request withdrawn mid-drain is still taken; the handler drops it as spurious
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state           <= ST_IDLE;
         drain_request   <= 1'b0;
         interrupt_taken <= 1'b0;
      end
      else
      begin
         interrupt_taken <= 1'b0;
         case (state)
            ST_IDLE:
               if (deliverable && !privileged_library_mode)
               begin
                  state         <= ST_DRAIN;
                  drain_request <= 1'b1;
               end
            ST_DRAIN:
               if (pipe_drained)
               begin
                  state           <= ST_TAKE;
                  drain_request   <= 1'b0;
                  interrupt_taken <= 1'b1;
               end
            ST_TAKE:
               state <= ST_IDLE;
            default:
            begin
               state         <= ST_IDLE;
               drain_request <= 1'b0;
            end
         endcase
      end
   end

   property p_no_take_in_library;
      (state == ST_IDLE && privileged_library_mode) |=> (state == ST_IDLE);
   endproperty
   a_no_take_in_library: assert property (p_no_take_in_library)
      else $error("delivery started inside library code");
   property p_drain_before_take;
      $rose(interrupt_taken) |-> $past(drain_request) && $past(pipe_drained);
   endproperty
   a_drain_before_take: assert property (p_drain_before_take)
      else $error("interrupt taken without a drained pipeline");
   wire logic take_now = (state == ST_DRAIN) && pipe_drained;

   // The hardware save outranks a software write in the same cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         restart_addr            <= RST_RESTART_ADDR;
         privileged_library_mode <= RST_PRIV_MODE;
      end
      else if (take_now)
      begin
         restart_addr            <= restart_pc;
         privileged_library_mode <= 1'b1;
      end
      else
      begin
         if (wr_ok && (register_index == IDX_EXCEPTION_RESTART_ADDRESS))
            restart_addr <= write_data;
         if (library_return)
            privileged_library_mode <= restart_addr[EXC_MODE_BIT];
      end
   end
   property p_take_saves_address;
      take_now |=> (restart_addr == $past(restart_pc)) && privileged_library_mode
                   && interrupt_taken;
   endproperty
   a_take_saves_address: assert property (p_take_saves_address)
      else $error("restart address or mode not set on take");

   // ******************************************************
   // Register reads
   // ******************************************************
   logic [63:0] summary;
   logic [63:0] next_read_data;

   always_comb
   begin
      summary = 64'h0;
      summary[31:0] = level_req;
      summary[SUM_HALT_BIT]   = halt_lvl;
      summary[SUM_SERIAL_BIT] = serial_line_irq;
      summary[SUM_AST_LSB+:AST_MODES] = ast_req & ast_en;
   end

   always_comb
   begin
      next_read_data = 64'h0;
      case (register_index)
         IDX_INTERRUPT_SUMMARY:          next_read_data = summary;
         IDX_SOFTWARE_INTERRUPT_REQUEST: next_read_data[SWI_COUNT:SWI_LSB] = swi_req;
         IDX_ASYNC_TRAP_REQUEST:         next_read_data[AST_MODES-1:0] = ast_req;
         IDX_ASYNC_TRAP_ENABLE:          next_read_data[AST_MODES-1:0] = ast_en;
         IDX_EXCEPTION_RESTART_ADDRESS:  next_read_data = restart_addr;
         IDX_CURRENT_PRIORITY_LEVEL:     next_read_data[4:0] = priority_level;
         IDX_INTERRUPT_IDENTIFICATION:   next_read_data[4:0] = ident;
         IDX_FETCH_UNIT_CONTROL_STATUS:  next_read_data[FETCH_UNIT_CONTROL_STATUS_MASK_LSB+:EXT_PINS] = ext_mask;
         default:                        next_read_data = 64'h0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         read_data <= 64'h0;
      else if (rd_ok)
         read_data <= next_read_data;
   end
   property p_read_privileged;
      (move_from_internal_register && !privileged_library_mode) |=> $stable(read_data);
   endproperty
   a_read_privileged: assert property (p_read_privileged)
      else $error("register read outside library code");
endmodule : interrupt_priority_delivery

// *** rtl/irq_delivery_pkg.sv ***
package irq_delivery_pkg;

   // ******************************************************
   // Internal register indices
   // ******************************************************
   localparam logic [9:0] IDX_INTERRUPT_SUMMARY           = 10'h100;
   localparam logic [9:0] IDX_SOFTWARE_INTERRUPT_REQUEST  = 10'h108;
   localparam logic [9:0] IDX_ASYNC_TRAP_REQUEST          = 10'h109;
   localparam logic [9:0] IDX_ASYNC_TRAP_ENABLE           = 10'h10A;
   localparam logic [9:0] IDX_EXCEPTION_RESTART_ADDRESS   = 10'h10B;
   localparam logic [9:0] IDX_CURRENT_PRIORITY_LEVEL      = 10'h110;
   localparam logic [9:0] IDX_INTERRUPT_IDENTIFICATION    = 10'h111;
   localparam logic [9:0] IDX_HARDWARE_INTERRUPT_CLEAR    = 10'h115;
   localparam logic [9:0] IDX_FETCH_UNIT_CONTROL_STATUS   = 10'h118;

   // ******************************************************
   // Field positions
   // ******************************************************
   localparam int SWI_LSB          = 1;
   localparam int SWI_COUNT        = 15;
   localparam int AST_MODES        = 4;
   localparam int EXT_PINS         = 4;
   localparam int FETCH_UNIT_CONTROL_STATUS_MASK_LSB    = 0;
   localparam int CLR_CORR_BIT     = 0;
   localparam int CLR_PERF_BIT     = 1;
   localparam int SUM_HALT_BIT     = 32;
   localparam int SUM_SERIAL_BIT   = 33;
   localparam int SUM_AST_LSB      = 36;
   localparam int EXC_MODE_BIT     = 0;
   localparam int CFG_SYNC_CYCLES  = 2;

   // ******************************************************
   // Target priority levels
   // ******************************************************
   localparam logic [4:0] LVL_AST        = 5'h02;
   localparam logic [4:0] LVL_EXT_BASE   = 5'h14;
   localparam logic [4:0] LVL_PERF       = 5'h1D;
   localparam logic [4:0] LVL_POWERFAIL  = 5'h1E;
   localparam logic [4:0] LVL_MCHECK     = 5'h1F;

   // ******************************************************
   // Reset values
   // ******************************************************
   localparam logic [4:0]  RST_PRIORITY_LEVEL = 5'h1F;
   localparam logic [3:0]  RST_EXT_MASK       = 4'h0;
   localparam logic [63:0] RST_RESTART_ADDR   = 64'h0;
   localparam logic        RST_PRIV_MODE      = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DRAIN = 3'b010,
      ST_TAKE  = 3'b100
   } deliver_state_t;

endpackage : irq_delivery_pkg

// *** test/interrupt_priority_delivery_bench.sv ***
`timescale 1ns/100ps
module interrupt_priority_delivery_bench;
   import irq_delivery_pkg::*;

   typedef struct packed {
      logic [4:0]  lvl;
      logic [15:0] swi;
      logic [3:0]  ext;
      logic        pf;
      logic        mc;
      logic [4:0]  id;
   } row_t;

   localparam logic [3:0] STRAP = 4'hA;
   localparam int         LIMIT = 5000;

   logic        clk, reset_n, powerfail_irq, machine_check_irq, halt_irq;
   logic        perf_counter_event, correctable_error_event, serial_line_irq;
   logic        pipe_drained, library_return, move_to, move_from;
   logic        drain_request, interrupt_taken, privileged_library_mode, clock_config_valid;
   logic [1:0]  current_mode;
   logic [3:0]  ext_irq, src_a, src_b, drain_delay, clock_config;
   logic [9:0]  register_index;
   logic [63:0] restart_pc, write_data, read_data, rd_val, exp_sum;
   int          num_errors, num_checks, cycles;
   row_t        rows [12] = '{
      '{5'h00, 16'h0020, 4'h0, 1'b0, 1'b0, 5'h05},
      '{5'h05, 16'h0020, 4'h0, 1'b0, 1'b0, 5'h00},
      '{5'h04, 16'h8020, 4'h0, 1'b0, 1'b0, 5'h0F},
      '{5'h00, 16'h0002, 4'h0, 1'b0, 1'b0, 5'h01},
      '{5'h13, 16'h0000, 4'h1, 1'b0, 1'b0, 5'h14},
      '{5'h13, 16'h0000, 4'h8, 1'b0, 1'b0, 5'h17},
      '{5'h16, 16'h0000, 4'h4, 1'b0, 1'b0, 5'h00},
      '{5'h15, 16'h0000, 4'h4, 1'b0, 1'b0, 5'h16},
      '{5'h1D, 16'h0000, 4'h0, 1'b1, 1'b0, 5'h1E},
      '{5'h1E, 16'h0000, 4'h0, 1'b1, 1'b0, 5'h00},
      '{5'h1E, 16'h0000, 4'h0, 1'b0, 1'b1, 5'h1F},
      '{5'h00, 16'h0000, 4'h0, 1'b0, 1'b0, 5'h00}
   };

   interrupt_priority_delivery dut_u
   (
      .clk(clk),
      .reset_n(reset_n),
      .ext_irq(ext_irq),
      .powerfail_irq(powerfail_irq),
      .machine_check_irq(machine_check_irq),
      .halt_irq(halt_irq),
      .perf_counter_event(perf_counter_event),
      .correctable_error_event(correctable_error_event),
      .serial_line_irq(serial_line_irq),
      .current_mode(current_mode),
      .pipe_drained(pipe_drained),
      .restart_pc(restart_pc),
      .library_return(library_return),
      .move_to_internal_register(move_to),
      .move_from_internal_register(move_from),
      .register_index(register_index),
      .write_data(write_data),
      .read_data(read_data),
      .drain_request(drain_request),
      .interrupt_taken(interrupt_taken),
      .privileged_library_mode(privileged_library_mode),
      .clock_config(clock_config),
      .clock_config_valid(clock_config_valid)
   );

   irq_source_model src_u
   (
      .clk(clk),
      .reset_n(reset_n),
      .strap(STRAP),
      .src_a(src_a),
      .src_b(src_b),
      .drain_request(drain_request),
      .drain_delay(drain_delay),
      .ext_irq(ext_irq),
      .pipe_drained(pipe_drained)
   );

   always #4 clk = ~clk;

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [9:0] idx, input logic [63:0] data);
      @(posedge clk);
      move_to        <= 1'b1;
      register_index <= idx;
      write_data     <= data;
      @(posedge clk);
      move_to <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] idx);
      @(posedge clk);
      move_from      <= 1'b1;
      register_index <= idx;
      @(posedge clk);
      move_from <= 1'b0;
      #1;
      rd_val = read_data;
   endtask : rd

   // Drain must be seen complete before the take pulse
   task automatic wait_take();
      int   n;
      logic seen_drain;
      n = 0;
      seen_drain = 1'b0;
      while (interrupt_taken !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         #1;
         if (drain_request === 1'b1 && pipe_drained === 1'b1)
            seen_drain = 1'b1;
         n++;
      end
      check("taken", interrupt_taken, 1);
      check("drained first", seen_drain, 1);
      check("library mode", privileged_library_mode, 1);
   endtask : wait_take

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      {powerfail_irq, machine_check_irq, halt_irq, perf_counter_event} = 4'h0;
      {correctable_error_event, serial_line_irq, library_return, move_to, move_from} = 5'h0;
      {current_mode, src_a, src_b, register_index} = '0;
      drain_delay = 4'h3;
      write_data = 64'h0;
      restart_pc = 64'h00AB_CDE0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[i])
      begin
         wr(IDX_CURRENT_PRIORITY_LEVEL, {59'h0, rows[i].lvl});
         wr(IDX_SOFTWARE_INTERRUPT_REQUEST, {48'h0, rows[i].swi});
         src_a             <= rows[i].ext;
         powerfail_irq     <= rows[i].pf;
         machine_check_irq <= rows[i].mc;
         exp_sum = {32'h0, rows[i].mc, rows[i].pf, 6'h0, rows[i].ext, 4'h0, rows[i].swi};
         repeat (4) @(posedge clk);
         rd(IDX_INTERRUPT_IDENTIFICATION);
         check("id", rd_val, {59'h0, rows[i].id});
         rd(IDX_INTERRUPT_SUMMARY);
         check("summary", rd_val, exp_sum);
      end
      $display("table tests done");

      @(posedge clk) reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("mode in reset", privileged_library_mode, 1);
      check("valid in reset", clock_config_valid, 0);
      @(posedge clk) reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check("config", clock_config, STRAP);
      check("config valid", clock_config_valid, 1);
      rd(IDX_CURRENT_PRIORITY_LEVEL);
      check("level after reset", rd_val, 64'h1F);
      rd(10'h3FF);
      check("unmapped", rd_val, 64'h0);
      $display("reset test done");

      wr(IDX_CURRENT_PRIORITY_LEVEL, 64'h0);
      wr(IDX_FETCH_UNIT_CONTROL_STATUS, 64'h1);
      src_a <= 4'h1;
      src_b <= 4'h2;
      repeat (4) @(posedge clk);
      rd(IDX_INTERRUPT_IDENTIFICATION);
      check("masked id", rd_val, 64'h15);
      rd(IDX_INTERRUPT_SUMMARY);
      check("masked summary", rd_val, 64'h20_0000);
      wr(IDX_FETCH_UNIT_CONTROL_STATUS, 64'h0);
      src_a <= 4'h0;
      src_b <= 4'h0;
      wr(IDX_ASYNC_TRAP_REQUEST, 64'h8);
      wr(IDX_ASYNC_TRAP_ENABLE, 64'h8);
      current_mode <= 2'h2;
      repeat (3) @(posedge clk);
      rd(IDX_INTERRUPT_IDENTIFICATION);
      check("trap outer mode", rd_val, 64'h0);
      @(posedge clk) {current_mode, serial_line_irq} <= 3'b111;
      rd(IDX_INTERRUPT_IDENTIFICATION);
      check("trap id", rd_val, 64'h2);
      rd(IDX_INTERRUPT_SUMMARY);
      check("trap summary", rd_val, 64'h82_0000_0004);
      wr(IDX_ASYNC_TRAP_REQUEST, 64'h0);
      serial_line_irq <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk) {perf_counter_event, correctable_error_event} <= 2'b01 << k;
         @(posedge clk) {perf_counter_event, correctable_error_event} <= 2'b00;
         repeat (2) @(posedge clk);
         rd(IDX_INTERRUPT_IDENTIFICATION);
         check("sticky id", rd_val, k ? 64'h1D : 64'h1F);
         wr(IDX_HARDWARE_INTERRUPT_CLEAR, 64'h1 << k);
         rd(IDX_INTERRUPT_IDENTIFICATION);
         check("cleared id", rd_val, 64'h0);
      end
      $display("source tests done");

      // Halt must wait while library code runs
      wr(IDX_EXCEPTION_RESTART_ADDRESS, 64'h1000);
      @(posedge clk) halt_irq <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check("held in library", drain_request, 0);
      @(posedge clk) library_return <= 1'b1;
      @(posedge clk) library_return <= 1'b0;
      wait_take();
      rd(IDX_EXCEPTION_RESTART_ADDRESS);
      check("restart address", rd_val, 64'h00AB_CDE0);
      @(posedge clk) halt_irq <= 1'b0;
      restart_pc  <= 64'h0012_3450;
      drain_delay <= 4'h0;
      wr(IDX_EXCEPTION_RESTART_ADDRESS, 64'h2000);
      @(posedge clk) library_return <= 1'b1;
      @(posedge clk) library_return <= 1'b0;
      // Outside library mode both accesses are ignored
      wr(IDX_CURRENT_PRIORITY_LEVEL, 64'h1F);
      rd(IDX_CURRENT_PRIORITY_LEVEL);
      check("refused read", rd_val, 64'h00AB_CDE0);
      @(posedge clk) src_a <= 4'h4;
      wait_take();
      rd(IDX_INTERRUPT_IDENTIFICATION);
      check("taken id", rd_val, 64'h16);
      rd(IDX_EXCEPTION_RESTART_ADDRESS);
      check("second restart", rd_val, 64'h0012_3450);
      $display("delivery tests done");
      print_verdict();
   end
endmodule : interrupt_priority_delivery_bench

// *** test/irq_source_model.sv ***
`timescale 1ns/100ps
// ************************************************
// System interrupt sources and pipeline drain model
// ************************************************
module irq_source_model
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [3:0] strap,
   input  wire logic [3:0] src_a,
   input  wire logic [3:0] src_b,
   input  wire logic       drain_request,
   input  wire logic [3:0] drain_delay,
   output logic [3:0]      ext_irq,
   output logic            pipe_drained
);
   logic [1:0] strap_age;
   logic [3:0] drain_age;

   // Straps must stand through reset and three edges after release
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         strap_age <= 2'h0;
      else if (strap_age != 2'h3)
         strap_age <= strap_age + 2'h1;

   // Shared sources are a plain OR; a withdrawn request drops at once
   assign ext_irq = (!reset_n || strap_age != 2'h3) ? strap : (src_a | src_b);

   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         drain_age <= 4'h0;
      else if (!drain_request)
         drain_age <= 4'h0;
      else if (drain_age != 4'hF)
         drain_age <= drain_age + 4'h1;

   // A slow pipeline answers only after drain_delay cycles
   assign pipe_drained = drain_request && (drain_age >= drain_delay);
endmodule : irq_source_model
